// *** rtl/ssl_synth_ctrl.sv ***
// Synthesizer serial load and control top: dividers, pump outputs, power control, APB
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ssl_synth_ctrl
  import ssl_pkg::*;
#(
  parameter bit TOP_VARIANT = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [APB_DATA_W-1:0]      prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic                  serClk,
  input  wire logic                  serData,
  input  wire logic                  loadStrobe,
  input  wire logic                  phasePolaritySelect,
  input  wire logic                  sleepRequestN,
  input  wire logic                  oscIn,
  input  wire logic                  finIn,
  output logic                       pumpOut,
  output logic                       pumpOutOeN,
  output logic                       loopSwitchOut,
  output logic                       loopSwitchOutOeN,
  output logic                       lockIndicator,
  output logic                       compMonitor,
  output logic                       extPumpPOut,
  output logic                       extPumpPOeN,
  output logic                       extPumpR
);

  function automatic logic regHit(input logic [APB_ADDR_W-1:0] addr, input logic [7:0] ofs);
    regHit = (addr == ofs);
  endfunction

  function automatic logic regMapped(input logic [APB_ADDR_W-1:0] addr);
    regMapped = regHit(addr, OFS_CTRL) | regHit(addr, OFS_STATUS) | regHit(addr, OFS_INT_STATUS) |
                regHit(addr, OFS_INT_ENABLE) | regHit(addr, OFS_INT_CLEAR) |
                regHit(addr, OFS_REF_LATCH) | regHit(addr, OFS_FEED_LATCH);
  endfunction

  // Pin synchronisers and edge detection
  logic [PIN_W-1:0] pinA_reg, pinB_reg, pinPrev_reg;
  logic             oscRise, finRise, polarityNormal, sleepReqN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinA_reg    <= PIN_RESET;
      pinB_reg    <= PIN_RESET;
      pinPrev_reg <= PIN_RESET;
    end else if (ce) begin
      pinA_reg    <= {sleepRequestN, phasePolaritySelect, finIn, oscIn};
      pinB_reg    <= pinA_reg;
      pinPrev_reg <= pinB_reg;
    end
  end

  assign oscRise        = pinB_reg[PIN_OSC] & ~pinPrev_reg[PIN_OSC];
  assign finRise        = pinB_reg[PIN_FIN] & ~pinPrev_reg[PIN_FIN];
  assign polarityNormal = pinB_reg[PIN_POL];
  assign sleepReqN      = pinB_reg[PIN_SLEEP_N];

  // Serial receiver
  logic [WORD_W-1:0] loadWord;
  logic              loadPulse, loadLevel;

  ssl_serial_shift #(
    .WIDTH      (WORD_W)
  ) u_shift (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .serClk     (serClk),
    .serData    (serData),
    .loadStrobe (loadStrobe),
    .loadWord   (loadWord),
    .loadPulse  (loadPulse),
    .loadLevel  (loadLevel)
  );

  // Latches, control register, power state
  logic [REF_W-1:0]     refLatch_reg, refLatch_next;
  logic [PAYLOAD_W-1:0] feedLatch_reg, feedLatch_next;
  logic [CTRL_W-1:0]    ctrl_reg, ctrl_next;
  ssl_power_type        pwr_reg, pwr_next;
  logic                 running, pumpUp, pumpDown, locked, pumpIdle;

  assign pumpIdle = ~pumpUp & ~pumpDown;
  assign running  = (pwr_reg != PWR_SLEEP);

  always_comb begin
    refLatch_next  = refLatch_reg;
    feedLatch_next = feedLatch_reg;
    if (loadPulse) begin
      // Last bit shifted in is the control bit
      if (loadWord[0] == CTRL_BIT_REF) begin
        refLatch_next = loadWord[REF_W:1];
      end else begin
        feedLatch_next = loadWord[WORD_W-1:1];
      end
    end
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_RUN: begin
        if (!sleepReqN) begin
          pwr_next = PWR_WAIT_IDLE;
        end
      end
      PWR_WAIT_IDLE: begin
        if (sleepReqN) begin
          pwr_next = PWR_RUN;
        end else if (pumpIdle) begin
          pwr_next = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (sleepReqN) begin
          pwr_next = PWR_RUN;
        end
      end
      default: pwr_next = PWR_RUN;
    endcase
  end

  // Reference divider and dual-modulus feedback divider
  logic [REF_W-1:0]     refCnt_reg, refCnt_next;
  logic [PRESC_W-1:0]   presCnt_reg, presCnt_next;
  logic [SWALLOW_W-1:0] swCnt_reg, swCnt_next;
  logic [MAIN_W-1:0]    mainCnt_reg, mainCnt_next;
  logic                 refPulse, fbPulse, refPhase_reg, fbPhase_reg;
  logic [PRESC_W-1:0]   presModulus, presTop;
  logic [REF_W-1:0]     refDiv;
  logic [SWALLOW_W-1:0] swallowLoad;
  logic [MAIN_W-1:0]    mainLoad;

  always_comb begin
    if (TOP_VARIANT) begin
      presModulus = ctrl_reg[CTRL_PRESC_BIT] ? PRESC_HI_TOP : PRESC_LO_TOP;
    end else begin
      presModulus = ctrl_reg[CTRL_PRESC_BIT] ? PRESC_HI_STD : PRESC_LO_STD;
    end
    swallowLoad = feedLatch_reg[SWALLOW_W-1:0];
    // A zero divide value would stall the loop; treat it as one
    mainLoad    = (feedLatch_reg[PAYLOAD_W-1:SWALLOW_W] == '0) ? MAIN_W'(1) : feedLatch_reg[PAYLOAD_W-1:SWALLOW_W];
    refDiv      = (refLatch_reg == '0) ? REF_W'(1) : refLatch_reg;
    // Modulus P+1 while swallowing, P otherwise; counter runs 0..top
    presTop     = (swCnt_reg != '0) ? presModulus : presModulus - 1'b1;
    refCnt_next  = refCnt_reg;
    presCnt_next = presCnt_reg;
    swCnt_next   = swCnt_reg;
    mainCnt_next = mainCnt_reg;
    refPulse     = 1'b0;
    fbPulse      = 1'b0;
    if (!running) begin
      refCnt_next  = '0;
      presCnt_next = '0;
      swCnt_next   = swallowLoad;
      mainCnt_next = mainLoad;
    end else begin
      if (oscRise) begin
        if (refCnt_reg >= refDiv - 1'b1) begin
          refCnt_next = '0;
          refPulse    = 1'b1;
        end else begin
          refCnt_next = refCnt_reg + 1'b1;
        end
      end
      if (finRise) begin
        if (presCnt_reg >= presTop) begin
          presCnt_next = '0;
          if (swCnt_reg != '0) begin
            swCnt_next = swCnt_reg - 1'b1;
          end
          if (mainCnt_reg <= MAIN_W'(1)) begin
            fbPulse      = 1'b1;
            swCnt_next   = swallowLoad;
            mainCnt_next = mainLoad;
          end else begin
            mainCnt_next = mainCnt_reg - 1'b1;
          end
        end else begin
          presCnt_next = presCnt_reg + 1'b1;
        end
      end
    end
  end

  ssl_phase_det u_pd (
    .clk            (clk),
    .rst            (rst),
    .ce             (ce),
    .enable         (running & (pwr_next != PWR_SLEEP)),
    .refPulse       (refPulse),
    .fbPulse        (fbPulse),
    .polarityNormal (polarityNormal),
    .pumpUp         (pumpUp),
    .pumpDown       (pumpDown),
    .locked         (locked)
  );

  // APB slave: zero wait states, read data captured in the setup cycle
  logic [APB_DATA_W-1:0] rdata_reg, rdata_next;
  logic [EV_W-1:0]       intStatus_reg, intStatus_next;
  logic [EV_W-1:0]       intEnable_reg, intEnable_next;
  logic [EV_W-1:0]       events, intClear;
  logic [ST_W-1:0]       status;
  logic                  lockPrev_reg, sleepPrev_reg, wrAccess;

  assign wrAccess = psel & penable & pwrite & pstrb[0];

  always_comb begin
    status                = '0;
    status[ST_LOCK_BIT]   = locked;
    status[ST_WAIT_BIT]   = (pwr_reg == PWR_WAIT_IDLE);
    status[ST_SLEEP_BIT]  = ~running;
    status[ST_UP_BIT]     = pumpUp;
    status[ST_DOWN_BIT]   = pumpDown;
    status[ST_SWITCH_BIT] = loadLevel;
    events                = '0;
    events[EV_LOCK_GAIN]  = locked & ~lockPrev_reg;
    events[EV_LOCK_LOSS]  = ~locked & lockPrev_reg;
    events[EV_LOAD_DONE]  = loadPulse;
    events[EV_SLEEP]      = ~running & ~sleepPrev_reg;
    intClear              = (wrAccess && regHit(paddr, OFS_INT_CLEAR)) ? pwdata[EV_W-1:0] : '0;
    // New events win over a clear in the same cycle
    intStatus_next        = (intStatus_reg & ~intClear) | events;
    intEnable_next        = (wrAccess && regHit(paddr, OFS_INT_ENABLE)) ? pwdata[EV_W-1:0] : intEnable_reg;
    ctrl_next             = (wrAccess && regHit(paddr, OFS_CTRL)) ? pwdata[CTRL_W-1:0] : ctrl_reg;
    rdata_next            = rdata_reg;
    if (psel && !penable) begin
      rdata_next = '0;
      if (regHit(paddr, OFS_CTRL))       rdata_next[CTRL_W-1:0]    = ctrl_reg;
      if (regHit(paddr, OFS_STATUS))     rdata_next[ST_W-1:0]      = status;
      if (regHit(paddr, OFS_INT_STATUS)) rdata_next[EV_W-1:0]      = intStatus_reg;
      if (regHit(paddr, OFS_INT_ENABLE)) rdata_next[EV_W-1:0]      = intEnable_reg;
      if (regHit(paddr, OFS_REF_LATCH))  rdata_next[REF_W-1:0]     = refLatch_reg;
      if (regHit(paddr, OFS_FEED_LATCH)) rdata_next[PAYLOAD_W-1:0] = feedLatch_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refLatch_reg  <= '0;
      feedLatch_reg <= '0;
      ctrl_reg      <= CTRL_RESET;
      pwr_reg       <= PWR_RUN;
      refCnt_reg    <= '0;
      presCnt_reg   <= '0;
      swCnt_reg     <= '0;
      mainCnt_reg   <= '0;
      refPhase_reg  <= 1'b0;
      fbPhase_reg   <= 1'b0;
      rdata_reg     <= '0;
      intStatus_reg <= EV_RESET;
      intEnable_reg <= EV_RESET;
      lockPrev_reg  <= 1'b0;
      sleepPrev_reg <= 1'b0;
    end else if (ce) begin
      refLatch_reg  <= refLatch_next;
      feedLatch_reg <= feedLatch_next;
      ctrl_reg      <= ctrl_next;
      pwr_reg       <= pwr_next;
      refCnt_reg    <= refCnt_next;
      presCnt_reg   <= presCnt_next;
      swCnt_reg     <= swCnt_next;
      mainCnt_reg   <= mainCnt_next;
      refPhase_reg  <= refPhase_reg ^ refPulse;
      fbPhase_reg   <= fbPhase_reg ^ fbPulse;
      rdata_reg     <= rdata_next;
      intStatus_reg <= intStatus_next;
      intEnable_reg <= intEnable_next;
      lockPrev_reg  <= locked;
      sleepPrev_reg <= ~running;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~regMapped(paddr);
  assign irq     = |(intStatus_reg & intEnable_reg);

  // Pin outputs; enables are active low
  assign pumpOut          = pumpUp;
  assign pumpOutOeN       = pumpIdle;
  assign loopSwitchOut    = pumpUp;
  assign loopSwitchOutOeN = ~(loadLevel & ~pumpIdle);
  // Low during each correction pulse, so lock shows as high with narrow dips
  assign lockIndicator    = locked & pumpIdle;
  assign compMonitor      = ctrl_reg[CTRL_MON_BIT] ? fbPhase_reg : refPhase_reg;
  assign extPumpPOut      = 1'b0;
  assign extPumpPOeN      = ~pumpDown;
  assign extPumpR         = pumpUp;

endmodule

// *** shared/ssl_pkg.sv ***
// Shared constants and types for the synthesizer serial load and control block
package ssl_pkg;

  // APB register map, byte addresses
  localparam int          APB_ADDR_W      = 8;
  localparam int          APB_DATA_W      = 32;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_INT_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_INT_ENABLE  = 8'h0c;
  localparam logic [7:0]  OFS_INT_CLEAR   = 8'h10;
  localparam logic [7:0]  OFS_REF_LATCH   = 8'h14;
  localparam logic [7:0]  OFS_FEED_LATCH  = 8'h18;

  // Control register fields
  localparam int          CTRL_PRESC_BIT  = 0;
  localparam int          CTRL_MON_BIT    = 1;
  localparam int          CTRL_W          = 2;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // Status register fields
  localparam int          ST_LOCK_BIT     = 0;
  localparam int          ST_WAIT_BIT     = 1;
  localparam int          ST_SLEEP_BIT    = 2;
  localparam int          ST_UP_BIT       = 3;
  localparam int          ST_DOWN_BIT     = 4;
  localparam int          ST_SWITCH_BIT   = 5;
  localparam int          ST_W            = 6;

  // Interrupt events
  localparam int          EV_LOCK_GAIN    = 0;
  localparam int          EV_LOCK_LOSS    = 1;
  localparam int          EV_LOAD_DONE    = 2;
  localparam int          EV_SLEEP        = 3;
  localparam int          EV_W            = 4;
  localparam logic [3:0]  EV_RESET        = 4'h0;

  // Serial word layout: {payload, control bit}
  localparam int          REF_W           = 14;
  localparam int          SWALLOW_W       = 7;
  localparam int          MAIN_W          = 11;
  localparam int          PAYLOAD_W       = SWALLOW_W + MAIN_W;
  localparam int          WORD_W          = PAYLOAD_W + 1;
  localparam logic        CTRL_BIT_REF    = 1'b0;
  localparam logic        CTRL_BIT_FEED   = 1'b1;

  // Prescaler moduli P (the divider runs P or P+1)
  localparam int          PRESC_W         = 8;
  localparam logic [7:0]  PRESC_LO_STD    = 8'h40;
  localparam logic [7:0]  PRESC_HI_STD    = 8'h80;
  localparam logic [7:0]  PRESC_LO_TOP    = 8'h20;
  localparam logic [7:0]  PRESC_HI_TOP    = 8'h40;

  // Lock detection
  localparam int          LOCK_CNT_W      = 3;
  localparam logic [2:0]  LOCK_WINDOW     = 3'h2;
  localparam logic [2:0]  LOCK_COUNT      = 3'h4;

  // Pin synchroniser lanes in the top module
  localparam int          PIN_OSC         = 0;
  localparam int          PIN_FIN         = 1;
  localparam int          PIN_POL         = 2;
  localparam int          PIN_SLEEP_N     = 3;
  localparam int          PIN_W           = 4;
  localparam logic [3:0]  PIN_RESET       = 4'hc;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT_IDLE, PWR_SLEEP} ssl_power_type;

endpackage

// *** rtl/ssl_serial_shift.sv ***
// Three-wire serial receiver: synchroniser, shift register and load capture
`timescale 1ns/1ps
module ssl_serial_shift
  import ssl_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             serClk,
  input  wire logic             serData,
  input  wire logic             loadStrobe,
  output logic [WIDTH-1:0]      loadWord,
  output logic                  loadPulse,
  output logic                  loadLevel
);

  // Lane 0 clock, 1 data, 2 strobe; strobe idles high (pull-up)
  localparam logic [2:0] SYNC_RESET = 3'h4;

  logic [2:0]       syncA_reg, syncB_reg, prev_reg;
  logic [WIDTH-1:0] shift_reg, shift_next;
  logic [WIDTH-1:0] word_reg, word_next;
  logic             pulse_reg, pulse_next;
  logic             clkRise, strobeRise;

  assign clkRise    = syncB_reg[0] & ~prev_reg[0];
  assign strobeRise = syncB_reg[2] & ~prev_reg[2];

  always_comb begin
    shift_next = shift_reg;
    word_next  = word_reg;
    pulse_next = 1'b0;
    if (clkRise) begin
      shift_next = {shift_reg[WIDTH-2:0], syncB_reg[1]};
    end
    // Host keeps the serial clock low around strobe edges, so no shift races the capture
    if (strobeRise) begin
      word_next  = shift_reg;
      pulse_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= SYNC_RESET;
      syncB_reg <= SYNC_RESET;
      prev_reg  <= SYNC_RESET;
      shift_reg <= '0;
      word_reg  <= '0;
      pulse_reg <= 1'b0;
    end else if (ce) begin
      syncA_reg <= {loadStrobe, serData, serClk};
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
      shift_reg <= shift_next;
      word_reg  <= word_next;
      pulse_reg <= pulse_next;
    end
  end

  assign loadWord  = word_reg;
  assign loadPulse = pulse_reg;
  assign loadLevel = prev_reg[2];

endmodule

// *** rtl/ssl_phase_det.sv ***
// Phase-frequency comparator with polarity select and lock detection
`timescale 1ns/1ps
module ssl_phase_det
  import ssl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic refPulse,
  input  wire logic fbPulse,
  input  wire logic polarityNormal,
  output logic      pumpUp,
  output logic      pumpDown,
  output logic      locked
);

  logic                  upRaw_reg, upRaw_next;
  logic                  dnRaw_reg, dnRaw_next;
  logic                  up_reg, up_next;
  logic                  dn_reg, dn_next;
  logic [LOCK_CNT_W-1:0] gap_reg, gap_next;
  logic [LOCK_CNT_W-1:0] good_reg, good_next;
  logic                  lock_reg, lock_next;
  logic                  setUp, setDn;

  always_comb begin
    upRaw_next = upRaw_reg;
    dnRaw_next = dnRaw_reg;
    gap_next   = gap_reg;
    good_next  = good_reg;
    setUp      = upRaw_reg | refPulse;
    setDn      = dnRaw_reg | fbPulse;
    if (!enable) begin
      upRaw_next = 1'b0;
      dnRaw_next = 1'b0;
      gap_next   = '0;
      good_next  = '0;
    end else if (setUp && setDn) begin
      // Both edges seen: pump returns to high impedance
      upRaw_next = 1'b0;
      dnRaw_next = 1'b0;
      gap_next   = '0;
      if (gap_reg <= LOCK_WINDOW) begin
        good_next = (good_reg == LOCK_COUNT) ? good_reg : good_reg + 1'b1;
      end else begin
        good_next = '0;
      end
    end else begin
      upRaw_next = setUp;
      dnRaw_next = setDn;
      if (setUp || setDn) begin
        // Saturate so a long phase error cannot wrap back into the window
        gap_next = (gap_reg > LOCK_WINDOW) ? gap_reg : gap_reg + 1'b1;
      end
    end
    up_next   = polarityNormal ? upRaw_next : dnRaw_next;
    dn_next   = polarityNormal ? dnRaw_next : upRaw_next;
    lock_next = (good_next == LOCK_COUNT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upRaw_reg <= 1'b0;
      dnRaw_reg <= 1'b0;
      up_reg    <= 1'b0;
      dn_reg    <= 1'b0;
      gap_reg   <= '0;
      good_reg  <= '0;
      lock_reg  <= 1'b0;
    end else if (ce) begin
      upRaw_reg <= upRaw_next;
      dnRaw_reg <= dnRaw_next;
      up_reg    <= up_next;
      dn_reg    <= dn_next;
      gap_reg   <= gap_next;
      good_reg  <= good_next;
      lock_reg  <= lock_next;
    end
  end

  assign pumpUp   = up_reg;
  assign pumpDown = dn_reg;
  assign locked   = lock_reg;

endmodule

// *** bench/ssl_synth_ctrl_sva.sv ***
// Assertion checker for the synthesizer serial load and control top
`timescale 1ns/1ps
module ssl_synth_ctrl_chk
  import ssl_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  loadStrobe,
  input wire logic                  sleepRequestN,
  input wire logic                  pumpOut,
  input wire logic                  pumpOutOeN,
  input wire logic                  loopSwitchOut,
  input wire logic                  loopSwitchOutOeN,
  input wire logic                  lockIndicator,
  input wire logic                  extPumpPOut,
  input wire logic                  extPumpPOeN,
  input wire logic                  extPumpR
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire unmapped = (paddr > OFS_FEED_LATCH) || (paddr[1:0] != 2'h0);
  wire access   = psel && penable;
  // Five cycles covers the two-flop synchroniser plus the edge flop
  sequence strobeLow; (!loadStrobe)[*5]; endsequence
  sequence sleepHeld; (!sleepRequestN)[*6]; endsequence
  sequence pumpSettled; (!sleepRequestN && pumpOutOeN)[*2]; endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_unmapped_err: assert property (access |-> pslverr == unmapped) else $error("pslverr wrong");
  chk_unmapped_zero: assert property (access && !pwrite && unmapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_switch_off: assert property (strobeLow |-> loopSwitchOutOeN)
    else $error("loop switch on with strobe low");
  chk_switch_copy: assert property (!loopSwitchOutOeN |-> !pumpOutOeN && loopSwitchOut == pumpOut)
    else $error("loop switch not a pump copy");
  chk_lock_idle: assert property (lockIndicator |-> pumpOutOeN)
    else $error("lock high during correction");
  chk_drain_low: assert property (extPumpPOut == 1'b0)
    else $error("open drain output driven high");
  chk_ext_quiet: assert property (pumpOutOeN |-> extPumpPOeN && !extPumpR)
    else $error("external pump active while idle");
  chk_sleep_idle: assert property (sleepHeld ##0 pumpSettled |=> !sleepRequestN |-> pumpOutOeN)
    else $error("pump woke during sleep");
endmodule

bind ssl_synth_ctrl ssl_synth_ctrl_chk ssl_synth_ctrl_chk_i (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .loadStrobe, .sleepRequestN, .pumpOut, .pumpOutOeN, .loopSwitchOut,
  .loopSwitchOutOeN, .lockIndicator, .extPumpPOut, .extPumpPOeN, .extPumpR);

// *** bench/ssl_host_model.sv ***
// Host model driving the three-wire serial programming lines
`timescale 1ns/1ps
module ssl_host_model
  import ssl_pkg::*;
(
  output logic serClk,
  output logic serData,
  output logic loadStrobe
);
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    loadStrobe = 1'b1;
  end
  // Link clock runs only inside a frame, 400 ns period
  task automatic send_word(input logic [WORD_W-1:0] w);
    #130 loadStrobe = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      #100 serData = w[i];
      #100 serClk = 1'b1;
      #200 serClk = 1'b0;
    end
    // Released data line shows the inverse, not a held bit
    #100 serData = ~serData;
    #100 loadStrobe = 1'b1;
    #400;
  endtask
endmodule

// *** bench/ssl_synth_ctrl_test.sv ***
// Self-checking bench for the synthesizer serial load and control top
`timescale 1ns/1ps
module ssl_synth_ctrl_test
  import ssl_pkg::*;
();
  logic        clk, rst, psel, penable, pwrite, phasePolaritySelect, sleepRequestN, oscIn, finIn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, serClk, serData, loadStrobe, pumpOut, pumpOutOeN, loopSwitchOut;
  logic        loopSwitchOutOeN, lockIndicator, compMonitor, extPumpPOut, extPumpPOeN, extPumpR;
  int          fails, n_checks;

  ssl_synth_ctrl ssl_synth_ctrl_i (.clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .irq, .serClk, .serData, .loadStrobe, .phasePolaritySelect,
    .sleepRequestN, .oscIn, .finIn, .pumpOut, .pumpOutOeN, .loopSwitchOut, .loopSwitchOutOeN,
    .lockIndicator, .compMonitor, .extPumpPOut, .extPumpPOeN, .extPumpR);
  ssl_host_model ssl_host_model_i (.serClk, .serData, .loadStrobe);

  always #25 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Four clocks per edge so the synchroniser sees every level
  task automatic fin_edges(input int n);
    repeat (n) begin
      @(posedge clk);
      finIn <= 1'b1;
      cyc(2);
      finIn <= 1'b0;
      cyc(1);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    phasePolaritySelect = 1'b1;
    sleepRequestN = 1'b1;
    oscIn = 1'b0;
    finIn = 1'b0;
    fails = 0;
    n_checks = 0;
    cyc(2);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl rw", rd, 32'h2);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
    apb(1'b0, OFS_INT_CLEAR, 32'h0);
    chk("clear reads", rd, 32'h0);
    fin_edges(63);
    cyc(5);
    chk("mon 63", 32'(compMonitor), 32'h0);
    fin_edges(1);
    cyc(5);
    chk("mon 64", 32'(compMonitor), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h3);
    fin_edges(127);
    cyc(5);
    chk("mon 127", 32'(compMonitor), 32'h1);
    fin_edges(1);
    cyc(5);
    chk("mon 128", 32'(compMonitor), 32'h0);
    // Reference edge one clock ahead of every 64th feedback edge keeps each pair inside the window
    do_reset();
    repeat (4) begin
      fin_edges(63);
      oscIn <= 1'b1;
      fin_edges(1);
      oscIn <= 1'b0;
    end
    cyc(5);
    #1;
    chk("lock pin", 32'(lockIndicator), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("lock bit", 32'(rd[0]), 32'h1);
    for (int p = 1; p >= 0; p--) begin
      do_reset();
      phasePolaritySelect <= p[0];
      cyc(4);
      oscIn <= 1'b1;
      cyc(4);
      oscIn <= 1'b0;
      cyc(4);
      #1;
      chk("pump on", 32'(pumpOutOeN), 32'h0);
      chk("pump dir", 32'(pumpOut), 32'(p[0]));
      chk("switch on", 32'(loopSwitchOutOeN), 32'h0);
      chk("ext r", 32'(extPumpR), 32'(p[0]));
      chk("ext p oen", 32'(extPumpPOeN), 32'(p[0]));
    end
    // Pump left active, so sleep must wait for the feedback pulse
    @(posedge clk);
    sleepRequestN <= 1'b0;
    cyc(8);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("wait idle", 32'(rd[2:1]), 32'h1);
    fin_edges(64);
    cyc(8);
    #1;
    chk("pump off", 32'(pumpOutOeN), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("sleeping", 32'(rd[2:1]), 32'h2);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk("sleep ev", 32'(rd[3]), 32'h1);
    sleepRequestN <= 1'b1;
    ssl_host_model_i.send_word({4'h0, 14'h2a5c, 1'b0});
    apb(1'b0, OFS_REF_LATCH, 32'h0);
    chk("ref latch", rd, 32'h2a5c);
    apb(1'b0, OFS_FEED_LATCH, 32'h0);
    chk("feed kept", rd, 32'h0);
    ssl_host_model_i.send_word({11'h5a3, 7'h2c, 1'b1});
    apb(1'b0, OFS_FEED_LATCH, 32'h0);
    chk("feed latch", rd, {14'h0, 11'h5a3, 7'h2c});
    apb(1'b0, OFS_REF_LATCH, 32'h0);
    chk("ref kept", rd, 32'h2a5c);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk("load ev", 32'(rd[2]), 32'h1);
    apb(1'b1, OFS_INT_ENABLE, 32'h4);
    cyc(1);
    #1;
    chk("irq on", 32'(irq), 32'h1);
    apb(1'b1, OFS_INT_ENABLE, 32'h0);
    cyc(1);
    #1;
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, OFS_INT_ENABLE, 32'h4);
    apb(1'b1, OFS_INT_CLEAR, 32'h4);
    cyc(1);
    #1;
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk("load ev cleared", 32'(rd[2]), 32'h0);
    tally_and_finish();
  end
endmodule
